// File: logic/tbt_time_base.sv
`timescale 1ns/100ps
`include "tbt_cfg.svh"
// Overview of operation
// - Twenty-two stage divider clocked from oscillator
// - Divider feeds periodic irq and timers
// - Rate select: eight rates, 00 off, 10 reserved
// - Instruction cycle lasts four oscillator periods
// - Four phases plus system clock generated
// - Clock generator stops while sleeping
// - Two independent timers, timer mode only
// - Counts preset and read as three nibbles
// - Separate command port per timer
// - Rate codes pick divide 2^5,7,11,15
// - Count up on selected pulse rising edge
// - Overflow raises request to interrupt controller
// - Sleep or hold entry clears time base
// - Timer A priority three, B four
module tbt_time_base
	import tbt_pkg::*;
#(
	parameter int CNT_W = 12
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Power state from the core
	input wire logic sleep_active,
	input wire logic hold_active,
	// Register side
	input wire tbt_port_req_t port_req,
	input wire tbt_cnt_req_t cnt_req,
	input wire logic [1:0] irq_ack,
	// Interrupt side
	output tbt_irq_t irq_req,
	// Read data and status
	output logic [3:0] cnt_rdata,
	output logic [3:0] rate_sel_out,
	output logic [`TBT_BASE_STAGES-1:0] base_out,
	output tbt_phase_t phases
);
	localparam int NB = `TBT_BASE_STAGES;

	// Pick a divider stage whose period is osc divided by two to the n
	function automatic logic tap(input logic [NB-1:0] b, input int n);
		tap = b[n-1];
	endfunction : tap

	// Map timer rate code to divider stage
	function automatic int rate_tap(input logic [1:0] c);
		unique case (c)
			2'h0: rate_tap = `TBT_TAP_SEL0;
			2'h1: rate_tap = `TBT_TAP_SEL1;
			2'h2: rate_tap = `TBT_TAP_SEL2;
			default: rate_tap = `TBT_TAP_SEL3;
		endcase
	endfunction : rate_tap

	// Map periodic rate select to divider stage; bit 2 is the enable
	function automatic int base_rate_tap(input logic [3:0] r);
		unique case ({r[3], r[1:0]})
			3'h0: base_rate_tap = `TBT_BASE_TAP0;
			3'h1: base_rate_tap = `TBT_BASE_TAP1;
			3'h2: base_rate_tap = `TBT_BASE_TAP2;
			3'h3: base_rate_tap = `TBT_BASE_TAP3;
			3'h4: base_rate_tap = `TBT_BASE_TAP4;
			3'h5: base_rate_tap = `TBT_BASE_TAP5;
			3'h6: base_rate_tap = `TBT_BASE_TAP6;
			default: base_rate_tap = `TBT_BASE_TAP7;
		endcase
	endfunction : base_rate_tap

	// State registers
	logic [NB-1:0] base_q, base_d; // Time base divider
	logic [1:0] ph_q, ph_d; // Phase counter within one cycle
	logic [3:0] rate_q, rate_d; // Periodic rate select
	logic [3:0] cmd_q [2]; // Command ports
	logic [3:0] cmd_d [2];
	logic [CNT_W-1:0] cnt_q [2]; // Timer counts
	logic [CNT_W-1:0] cnt_d [2];
	logic [1:0] pls_q, pls_d; // Previous timer pulse level
	logic [1:0] ovf_q, ovf_d; // Pending overflow requests
	logic base_prev_q, base_prev_d; // Previous periodic tap level
	logic base_irq_q, base_irq_d; // Periodic request pulse
	logic [3:0] rdat_q, rdat_d; // Read data
	tbt_phase_t ph_out_q, ph_out_d; // Phase outputs
	logic base_tap; // Selected periodic tap
	logic [1:0] pls_now; // Current timer pulse levels

	// Time base, phases and periodic interrupt
	always_comb begin
		base_d = base_q;
		ph_d = ph_q;
		// Divider runs on the oscillator clock
		if (sleep_active || hold_active) begin
			base_d = '0;
		end else begin
			base_d = base_q + NB'(1);
		end
		// Phase generator halts in sleep
		if (!sleep_active) begin
			ph_d = ph_q + 2'(1);
		end
		ph_out_d.phase_one = !sleep_active && (ph_d == 2'h0);
		ph_out_d.phase_two = !sleep_active && (ph_d == 2'h1);
		ph_out_d.phase_three = !sleep_active && (ph_d == 2'h2);
		ph_out_d.phase_four = !sleep_active && (ph_d == 2'h3);
		ph_out_d.sys_clk = !sleep_active && !ph_d[1];
		// Selected periodic tap
		base_tap = tap(base_q, base_rate_tap(rate_q));
		// Last level seen through the next rate, so a rate change makes no false edge
		base_prev_d = tap(base_q, base_rate_tap(rate_d));
		// Enabled only when bit 2 set; codes 00 and 10 give none
		base_irq_d = rate_q[2] && base_tap && !base_prev_q;
	end

	// Time base registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			base_q <= '0;
			ph_q <= 2'h3;
			base_prev_q <= 1'b0;
			base_irq_q <= 1'b0;
			ph_out_q <= '0;
		end else begin
			base_q <= base_d;
			ph_q <= ph_d;
			base_prev_q <= base_prev_d;
			base_irq_q <= base_irq_d;
			ph_out_q <= ph_out_d;
		end
	end

	// Ports, timers and overflow requests
	always_comb begin
		rate_d = rate_q;
		rdat_d = rdat_q;
		// Periodic rate select port write
		if (port_req.wr && port_req.port == `TBT_PORT_RATE) begin
			rate_d = port_req.data;
		end
		for (int t = 0; t < 2; t++) begin
			cmd_d[t] = cmd_q[t];
			cnt_d[t] = cnt_q[t];
			ovf_d[t] = ovf_q[t];
			// Timer pulse from its selected tap
			pls_now[t] = tap(base_q, rate_tap(cmd_q[t][1:0]));
			// Separate command port per timer
			if (port_req.wr && port_req.port ==
				(t == 0 ? `TBT_PORT_TA_CMD : `TBT_PORT_TB_CMD)) begin
				cmd_d[t] = port_req.data;
			end
			// Last level seen through the next rate, so a rate change makes no false edge
			pls_d[t] = tap(base_q, rate_tap(cmd_d[t][1:0]));
			// Independent counting on rising pulse
			if (cmd_q[t][`TBT_CMD_EN_BIT] && pls_now[t] && !pls_q[t]) begin
				cnt_d[t] = cnt_q[t] + CNT_W'(1);
				if (&cnt_q[t]) begin
					ovf_d[t] = 1'b1;
				end
			end
			// Nibble preset write
			if (cnt_req.wr && int'(cnt_req.tmr) == t) begin
				unique case (cnt_req.nib)
					TBT_NIB_LOW: cnt_d[t][3:0] = cnt_req.data;
					TBT_NIB_MID: cnt_d[t][7:4] = cnt_req.data;
					default: cnt_d[t][11:8] = cnt_req.data;
				endcase
			end
			// Acknowledge clears; a new overflow wins
			if (irq_ack[t] && !(cmd_q[t][`TBT_CMD_EN_BIT] && pls_now[t] && !pls_q[t]
				&& (&cnt_q[t]))) begin
				ovf_d[t] = 1'b0;
			end
		end
		// Nibble read of current count
		if (cnt_req.rd) begin
			unique case (cnt_req.nib)
				TBT_NIB_LOW: rdat_d = cnt_q[cnt_req.tmr][3:0];
				TBT_NIB_MID: rdat_d = cnt_q[cnt_req.tmr][7:4];
				default: rdat_d = cnt_q[cnt_req.tmr][11:8];
			endcase
		end
	end

	// Port and timer registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			rate_q <= `TBT_RATE_RST;
			rdat_q <= 4'h0;
			pls_q <= 2'h0;
			ovf_q <= 2'h0;
			for (int t = 0; t < 2; t++) begin
				cmd_q[t] <= `TBT_CMD_RST;
				cnt_q[t] <= '0;
			end
		end else begin
			rate_q <= rate_d;
			rdat_q <= rdat_d;
			pls_q <= pls_d;
			ovf_q <= ovf_d;
			for (int t = 0; t < 2; t++) begin
				cmd_q[t] <= cmd_d[t];
				cnt_q[t] <= cnt_d[t];
			end
		end
	end

	// Outputs straight from flops; A is priority three, B four
	assign irq_req.tmr_a = ovf_q[0];
	assign irq_req.tmr_b = ovf_q[1];
	assign irq_req.base = base_irq_q;
	assign cnt_rdata = rdat_q;
	assign rate_sel_out = rate_q;
	assign base_out = base_q;
	assign phases = ph_out_q;

	// Checks
	// Sleep or hold empties the divider
	a_sleep_clears: assert property (@(posedge mclk) disable iff (rst)
		(sleep_active || hold_active) |=> base_q == '0)
		else $error("time base not cleared");
	// Phase one is followed by phase two
	a_phase_step: assert property (@(posedge mclk) disable iff (rst)
		ph_out_q.phase_one && !sleep_active |=> ph_out_q.phase_two || sleep_active)
		else $error("phase did not advance");
	// One instruction cycle spans four clocks
	a_cycle_len: assert property (@(posedge mclk) disable iff (rst)
		ph_out_q.phase_one && !sleep_active ##1 (!sleep_active) [*3]
		|=> ph_out_q.phase_one)
		else $error("instruction cycle not four clocks");
	// Exactly one phase while running
	a_phase_onehot: assert property (@(posedge mclk) disable iff (rst)
		!sleep_active |=> $onehot({ph_out_q.phase_one, ph_out_q.phase_two,
		ph_out_q.phase_three, ph_out_q.phase_four}))
		else $error("phases not one-hot");
	// System clock high in the first half of the cycle
	a_sys_clk: assert property (@(posedge mclk) disable iff (rst)
		!sleep_active |=> ph_out_q.sys_clk == (ph_out_q.phase_one || ph_out_q.phase_two))
		else $error("system clock out of step");
	// Clock generator halts in sleep
	a_phase_hold: assert property (@(posedge mclk) disable iff (rst)
		sleep_active |=> !ph_out_q.phase_one && !ph_out_q.sys_clk)
		else $error("clock ran in sleep");
	// Rate select takes the written value
	a_rate_write: assert property (@(posedge mclk) disable iff (rst)
		port_req.wr && port_req.port == `TBT_PORT_RATE |=> rate_q == $past(port_req.data))
		else $error("rate select not written");
	// No periodic request while disabled or reserved
	a_base_off: assert property (@(posedge mclk) disable iff (rst)
		!rate_q[2] |=> !base_irq_q)
		else $error("periodic irq while disabled");
	// Periodic request lasts one cycle
	a_base_pulse: assert property (@(posedge mclk) disable iff (rst)
		base_irq_q |=> !base_irq_q)
		else $error("periodic irq too long");
	// Timer B command port takes its write
	a_cmd_write: assert property (@(posedge mclk) disable iff (rst)
		port_req.wr && port_req.port == `TBT_PORT_TB_CMD |=> cmd_q[1] == $past(port_req.data))
		else $error("command not written");
	// Timer B port leaves timer A alone
	a_cmd_apart: assert property (@(posedge mclk) disable iff (rst)
		port_req.wr && port_req.port == `TBT_PORT_TB_CMD |=> cmd_q[0] == $past(cmd_q[0]))
		else $error("command ports not separate");
	// Disabled timer A holds its count
	a_hold_count: assert property (@(posedge mclk) disable iff (rst)
		!cmd_q[0][3] && !cnt_req.wr |=> cnt_q[0] == $past(cnt_q[0]))
		else $error("disabled timer moved");
	// Disabled timer B holds its count
	a_hold_count_b: assert property (@(posedge mclk) disable iff (rst)
		!cmd_q[1][3] && !cnt_req.wr |=> cnt_q[1] == $past(cnt_q[1]))
		else $error("disabled timer moved");
	// Timer B steps on a rising pulse
	a_count_step: assert property (@(posedge mclk) disable iff (rst)
		cmd_q[1][3] && pls_now[1] && !pls_q[1] && !cnt_req.wr
		|=> cnt_q[1] == $past(cnt_q[1]) + CNT_W'(1))
		else $error("count did not step");
	// Timer A steps on a rising pulse
	a_count_step_a: assert property (@(posedge mclk) disable iff (rst)
		cmd_q[0][3] && pls_now[0] && !pls_q[0] && !cnt_req.wr
		|=> cnt_q[0] == $past(cnt_q[0]) + CNT_W'(1))
		else $error("count did not step");
	// Timer A overflow raises its request
	a_ovf_set: assert property (@(posedge mclk) disable iff (rst)
		cmd_q[0][3] && pls_now[0] && !pls_q[0] && (&cnt_q[0]) |=> ovf_q[0])
		else $error("overflow not raised");
	// Timer B overflow raises its request
	a_ovf_set_b: assert property (@(posedge mclk) disable iff (rst)
		cmd_q[1][3] && pls_now[1] && !pls_q[1] && (&cnt_q[1]) |=> ovf_q[1])
		else $error("overflow not raised");
	// Full count wraps to zero
	a_wrap_zero: assert property (@(posedge mclk) disable iff (rst)
		cmd_q[0][3] && pls_now[0] && !pls_q[0] && (&cnt_q[0]) && !cnt_req.wr
		|=> cnt_q[0] == '0)
		else $error("count did not wrap");
	// Timer B request stays until acknowledged
	a_ovf_held: assert property (@(posedge mclk) disable iff (rst)
		ovf_q[1] && !irq_ack[1] |=> ovf_q[1])
		else $error("request dropped early");
	// Timer A request stays until acknowledged
	a_ovf_held_a: assert property (@(posedge mclk) disable iff (rst)
		ovf_q[0] && !irq_ack[0] |=> ovf_q[0])
		else $error("request dropped early");
	// Acknowledge clears timer A request without a new overflow
	a_ack_clears: assert property (@(posedge mclk) disable iff (rst)
		irq_ack[0] && !(cmd_q[0][3] && pls_now[0] && !pls_q[0] && (&cnt_q[0]))
		|=> !ovf_q[0])
		else $error("request not cleared");
	// Low nibble read returns the count of that cycle
	a_read_low: assert property (@(posedge mclk) disable iff (rst)
		cnt_req.rd && cnt_req.tmr == TBT_TMR_A && cnt_req.nib == TBT_NIB_LOW
		|=> cnt_rdata == 4'($past(cnt_q[0])))
		else $error("read data wrong");
endmodule : tbt_time_base

// File: logic/tbt_cfg.svh
`ifndef TBT_CFG_SVH
`define TBT_CFG_SVH
// Port numbers of the command and select ports
`define TBT_PORT_RATE 5'h19
`define TBT_PORT_TA_CMD 5'h1C
`define TBT_PORT_TB_CMD 5'h1D
// Reset values
`define TBT_RATE_RST 4'h0
`define TBT_CMD_RST 4'h0
// Command port fields
`define TBT_CMD_EN_BIT 3
// Pulse-rate taps on the time base (stage index of oscillator divide)
`define TBT_TAP_SEL0 5
`define TBT_TAP_SEL1 7
`define TBT_TAP_SEL2 11
`define TBT_TAP_SEL3 15
// Periodic interrupt taps for codes 0..7 of rate bits {3, 1:0}
`define TBT_BASE_TAP0 9
`define TBT_BASE_TAP1 10
`define TBT_BASE_TAP2 12
`define TBT_BASE_TAP3 13
`define TBT_BASE_TAP4 14
`define TBT_BASE_TAP5 15
`define TBT_BASE_TAP6 16
`define TBT_BASE_TAP7 17
// Time base length and instruction cycle length
`define TBT_BASE_STAGES 22
`define TBT_CYCLE_CLKS 4
`endif

// File: logic/tbt_pkg.sv
package tbt_pkg;
	// Timer selector
	typedef enum logic {TBT_TMR_A, TBT_TMR_B} tbt_tmr_t;
	// Count nibble selector
	typedef enum logic [1:0] {TBT_NIB_LOW, TBT_NIB_MID, TBT_NIB_HIGH} tbt_nib_t;
	// Count access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		tbt_tmr_t tmr;
		tbt_nib_t nib;
		logic [3:0] data;
	} tbt_cnt_req_t;
	// Port write from the core
	typedef struct packed {
		logic wr;
		logic [4:0] port;
		logic [3:0] data;
	} tbt_port_req_t;
	// Interrupt requests
	typedef struct packed {
		logic tmr_a;
		logic tmr_b;
		logic base;
	} tbt_irq_t;
	// Clock phases
	typedef struct packed {
		logic phase_one;
		logic phase_two;
		logic phase_three;
		logic phase_four;
		logic sys_clk;
	} tbt_phase_t;
endpackage : tbt_pkg

// File: sim/tbt_core_model.sv
`timescale 1ns/100ps
module tbt_core_model
	import tbt_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Requests, mask bits (bit0 timer A, bit1 timer B), wait length
	input wire tbt_irq_t irq_req,
	input wire logic [1:0] mask,
	input wire logic slow,
	// Acknowledge back to the block
	output logic [1:0] irq_ack
);
	int wait_cnt = 0; // Cycles a gated request has waited
	initial irq_ack = 2'h0;
	// Accept a gated overflow request after a short or a long wait
	always @(posedge mclk) begin
		#1;
		if (rst || irq_ack != 2'h0) begin
			irq_ack = 2'h0;
			wait_cnt = 0;
		end else if (({irq_req.tmr_b, irq_req.tmr_a} & mask) != 2'h0) begin
			wait_cnt++;
			if (wait_cnt > (slow ? 20 : 1)) begin
				irq_ack = {irq_req.tmr_b, irq_req.tmr_a} & mask;
			end
		end
	end
endmodule : tbt_core_model

// File: sim/time_base_and_dual_timers_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module time_base_and_dual_timers_tb;
	import tbt_pkg::*;
	// Stimulus
	logic mclk = 0, rst = 1, sleep_active = 0, hold_active = 0, slow = 0;
	logic [1:0] mask = 2'h0, irq_ack;
	tbt_port_req_t port_req = '0;
	tbt_cnt_req_t cnt_req = '0;
	// Observed outputs and scratch
	tbt_irq_t irq_req;
	tbt_phase_t phases, ph;
	logic [3:0] cnt_rdata, rate_sel_out, rd, d;
	logic [21:0] base_out;
	int errors = 0, tests_run = 0, cyc = 0, n, hits;
	logic [31:0] seed = 32'h31ED0C61;
	always #50 mclk = ~mclk;
	tbt_time_base u_dut (.mclk(mclk), .rst(rst), .sleep_active(sleep_active),
		.hold_active(hold_active), .port_req(port_req), .cnt_req(cnt_req),
		.irq_ack(irq_ack), .irq_req(irq_req), .cnt_rdata(cnt_rdata),
		.rate_sel_out(rate_sel_out), .base_out(base_out), .phases(phases));
	tbt_core_model u_core (.mclk(mclk), .rst(rst), .irq_req(irq_req), .mask(mask),
		.slow(slow), .irq_ack(irq_ack));
	// Xorshift source
	function automatic logic [3:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[3:0];
	endfunction : rnd
	// Time base stage index for a pulse-rate code
	function automatic int tap(int c);
		return c == 0 ? 5 : c == 1 ? 7 : c == 2 ? 11 : 15;
	endfunction : tap
	// Wait edges, then step just past the last one
	task automatic tick(int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick
	// One-cycle port write
	task automatic port_wr(logic [4:0] p, logic [3:0] v);
		tick(1);
		port_req = '{1'b1, p, v};
		tick(1);
		port_req = '0;
	endtask : port_wr
	// Count nibble write, or read into rd
	task automatic cnt_op(logic w, int t, int nb, logic [3:0] v);
		tick(1);
		cnt_req = '{w, !w, tbt_tmr_t'(t), tbt_nib_t'(nb), v};
		tick(1);
		cnt_req = '0;
		tick(1);
		rd = cnt_rdata;
	endtask : cnt_op
	task automatic close_out();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out
	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 80000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		tick(12);
		rst = 0;
		`CHK("rate_rst", 4'h0, rate_sel_out)
		`CHK("irq_rst", 3'h0, irq_req)
		tick(1);
		// Phases: one-hot, four clocks per instruction cycle
		ph = phases;
		`CHK("phase_hot", 1'b1, $onehot(ph[4:1]))
		`CHK("sys_clk", ph.phase_one | ph.phase_two, ph.sys_clk)
		tick(1);
		`CHK("phase_step", 1'b1, phases !== ph)
		tick(3);
		`CHK("phase_cycle", ph, phases)
		$display("test phases done");
		// Rate select read back, random values
		repeat (4) begin
			d = rnd();
			port_wr(5'h19, d);
			`CHK("rate_rd", d, rate_sel_out)
		end
		// Periodic request at 2^9, none when off or reserved
		for (int i = 0; i < 3; i++) begin
			d = i == 0 ? 4'h4 : i == 1 ? 4'h0 : 4'h8;
			port_wr(5'h19, d);
			hits = 0;
			repeat (1024) begin
				tick(1);
				hits += irq_req.base;
			end
			`CHK("base_irq", (i == 0) ? 2 : 0, hits)
		end
		$display("test periodic done");
		// Presets read back while both timers are idle
		port_wr(5'h1C, rnd() & 4'h7);
		for (int t = 0; t < 2; t++) for (int b = 0; b < 3; b++) begin
			d = rnd();
			cnt_op(1, t, b, d);
			cnt_op(0, t, b, 4'h0);
			`CHK("cnt_rd", d, rd)
		end
		$display("test presets done");
		// Each rate code: exactly one step in one period of its tap
		for (int c = 0; c < 4; c++) begin
			n = tap(c);
			for (int b = 0; b < 3; b++) cnt_op(1, 0, b, 4'h0);
			while (base_out[n-1] !== 1'b1) tick(1);
			while (base_out[n-1] !== 1'b0) tick(1);
			port_wr(5'h1C, 4'h8 | 4'(c));
			tick(1 << n);
			port_wr(5'h1C, 4'(c));
			cnt_op(0, 0, 0, 4'h0);
			`CHK("rate_step", 4'h1, rd)
		end
		$display("test rates done");
		// Overflow from FFF on each timer, held until a masked ack
		for (int t = 0; t < 2; t++) begin
			for (int b = 0; b < 3; b++) cnt_op(1, t, b, 4'hF);
			port_wr(t ? 5'h1D : 5'h1C, 4'h8);
			hits = 0;
			while (irq_req[2-t] !== 1'b1 && hits < 80) begin
				tick(1);
				hits++;
			end
			`CHK("ovf_irq", t ? 2'b01 : 2'b10, {irq_req.tmr_a, irq_req.tmr_b})
			cnt_op(0, t, 0, 4'h0);
			`CHK("wrap", 4'h0, rd)
			tick(30);
			`CHK("held", 1'b1, irq_req[2-t])
			slow = t[0];
			mask = 2'h1 << t;
			tick(40);
			`CHK("acked", 1'b0, irq_req[2-t])
			port_wr(t ? 5'h1D : 5'h1C, 4'h0);
			mask = 2'h0;
		end
		$display("test overflow done");
		// Hold clears the base with phases running; sleep stops them
		hold_active = 1;
		tick(2);
		ph = phases;
		`CHK("hold_base", 22'h0, base_out)
		tick(1);
		`CHK("hold_run", 1'b1, phases !== ph)
		hold_active = 0;
		sleep_active = 1;
		tick(2);
		ph = phases;
		tick(4);
		`CHK("sleep_base", 22'h0, base_out)
		`CHK("sleep_stop", ph, phases)
		sleep_active = 0;
		tick(8);
		`CHK("wake_run", 1'b1, base_out != 22'h0)
		$display("test power done");
		close_out();
	end
endmodule : time_base_and_dual_timers_tb
